// *** hw/safe_defs.vh ***
`ifndef SAFE_DEFS_VH
`define SAFE_DEFS_VH

// ----------------------------------------------------------------------------
// Target address and bus timing
// ----------------------------------------------------------------------------
// Seven-bit target address of the control port.
`define SAFE_TARGET_ADDR    7'h67
// Fastest supported serial clock, in kHz, and the reference clock in MHz.
`define SAFE_FAST_RATE_KHZ  400
`define SAFE_REF_CLK_MHZ    200
// Reference cycles in one fast-rate bit period.
`define SAFE_BIT_CYCLES     ((`SAFE_REF_CLK_MHZ * 1000) / `SAFE_FAST_RATE_KHZ)

// ----------------------------------------------------------------------------
// Register indices
// ----------------------------------------------------------------------------
`define SAFE_IDX_GAIN       8'h06
`define SAFE_IDX_CTRL       8'h08
`define SAFE_IDX_SEL1       8'h10
`define SAFE_IDX_SEL2       8'h12
`define SAFE_IDX_SEL3       8'h14
`define SAFE_IDX_SEL4       8'h15
`define SAFE_IDX_SEL5       8'h18
`define SAFE_IDX_SEL6       8'h1a
`define SAFE_IDX_SEL7       8'h1c
`define SAFE_IDX_SEL8       8'h1e
// Trim register of a channel sits at its select index plus this step.
`define SAFE_TRIM_STEP      8'h10

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define SAFE_TRIM_SIGN      10
`define SAFE_CTRL_SLEEP     0
`define SAFE_CTRL_LEVEL     1
`define SAFE_CTRL_REG_OFF   2
`define SAFE_CTRL_ISENSE    3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define SAFE_RST_CHAN       3'h0
`define SAFE_RST_GAIN       3'h0
`define SAFE_RST_TRIM       11'h000
`define SAFE_RST_CTRL       4'h0

`endif

// *** hw/safe_ctrl.v ***
// Summary of operation
// R1 - Trim is 11 bits: bit 10 sign, bits 9..0 magnitude.
// R2 - Three-bit gain code decodes to 2,20,40,80,150,300,600,760 V/V.
// R3 - Each of the eight channels keeps its own trim value.
// R4 - Only the selected channel's trim drives the offset converter.
// R5 - A control bit selects regulator level 3V or 2.65V.
// R6 - A control bit turns the regulator off during sleep.
// R7 - Current-sense mode routes regulator current signal to the output.
// R8 - Sleep powers down analog parts; the control port keeps working.
// R9 - Serial port is a target only, up to 400 kbps.
// R10 - Access: START, address, zero to two data bytes, STOP.
// R11 - Controller opens each transfer with SDA falling while SCL high.
// R12 - First byte after START is 7-bit address plus direction bit.
// R13 - Matching address is acknowledged by pulling SDA low one period.
// R14 - Next byte is register index, then up to two acked data bytes.
// R15 - Address bit 0 low means write, high means read.
// R16 - After reset channel 1 and gain 2 V/V are selected.
// R17 - Indices 0x10..0x1E select channels and carry no data.
// R18 - A foreign address leaves SDA released until the next START.
`timescale 1ns/1ps
`include "safe_defs.vh"

module safe_ctrl #(
  parameter [6:0] TARGET_ADDR = `SAFE_TARGET_ADDR
) (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        sys_rst,
  // Serial control pins
  input  wire        scl_i,
  input  wire        sda_i,
  output wire        sda_o,
  output reg         sda_oe,
  // Analog controls
  output reg  [2:0]  channel_selector,
  output reg  [10:0] active_trim,
  output reg         trim_sign_bit,
  output reg  [2:0]  amplifier_gain_code,
  output reg  [9:0]  programmable_amplifier_gain,
  output reg         regulator_level_low,
  output reg         bridge_supply_regulator_en,
  output reg         current_sense_sel,
  output reg         analog_power_down
);

  // --------------------------------------------------------------------------
  // Local definitions
  // --------------------------------------------------------------------------
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_ADDR = 3'h1;
  localparam [2:0] ST_ACK  = 3'h2;
  localparam [2:0] ST_RX   = 3'h3;
  localparam [2:0] ST_TX   = 3'h4;
  localparam [2:0] ST_RACK = 3'h5;
  localparam [2:0] ST_SKIP = 3'h6;

  // Maps a register index to {valid, channel}; used for select and trim.
  function [3:0] chan_of;
    input [7:0] idx;
    begin
      case (idx)
        `SAFE_IDX_SEL1: chan_of = 4'h8;
        `SAFE_IDX_SEL2: chan_of = 4'h9;
        `SAFE_IDX_SEL3: chan_of = 4'ha;
        `SAFE_IDX_SEL4: chan_of = 4'hb;
        `SAFE_IDX_SEL5: chan_of = 4'hc;
        `SAFE_IDX_SEL6: chan_of = 4'hd;
        `SAFE_IDX_SEL7: chan_of = 4'he;
        `SAFE_IDX_SEL8: chan_of = 4'hf;
        default:        chan_of = 4'h0;
      endcase
    end
  endfunction

  // Gain in V/V for a three-bit code.
  function [9:0] gain_of;
    input [2:0] code;
    begin
      case (code)
        3'h0:    gain_of = 10'd2;
        3'h1:    gain_of = 10'd20;
        3'h2:    gain_of = 10'd40;
        3'h3:    gain_of = 10'd80;
        3'h4:    gain_of = 10'd150;
        3'h5:    gain_of = 10'd300;
        3'h6:    gain_of = 10'd600;
        default: gain_of = 10'd760;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  reg  [2:0] scl_sync_reg;
  reg  [2:0] sda_sync_reg;
  reg        scl_lvl_reg;
  reg        sda_lvl_reg;
  wire       scl_ok  = (scl_sync_reg[1] == scl_sync_reg[2]);
  wire       sda_ok  = (sda_sync_reg[1] == sda_sync_reg[2]);
  wire       scl_new = scl_ok ? scl_sync_reg[2] : scl_lvl_reg;
  wire       sda_new = sda_ok ? sda_sync_reg[2] : sda_lvl_reg;
  wire       scl_rise = scl_new & ~scl_lvl_reg;
  wire       scl_fall = ~scl_new & scl_lvl_reg;
  // R11 start seen
  wire       start_det = scl_lvl_reg & scl_new & sda_lvl_reg & ~sda_new;
  wire       stop_det  = scl_lvl_reg & scl_new & ~sda_lvl_reg & sda_new;

  // A level only counts once the second and third stages agree.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      scl_sync_reg <= 3'h7;
      sda_sync_reg <= 3'h7;
      scl_lvl_reg  <= 1'b1;
      sda_lvl_reg  <= 1'b1;
    end else begin
      scl_sync_reg <= {scl_sync_reg[1:0], scl_i};
      sda_sync_reg <= {sda_sync_reg[1:0], sda_i};
      scl_lvl_reg  <= scl_new;
      sda_lvl_reg  <= sda_new;
    end
  end

  // --------------------------------------------------------------------------
  // Configuration storage
  // --------------------------------------------------------------------------
  reg  [10:0] trim_mem [0:7];
  reg  [2:0]  chan_reg;
  reg  [2:0]  gain_reg;
  reg  [3:0]  ctrl_reg;

  // --------------------------------------------------------------------------
  // Protocol state
  // --------------------------------------------------------------------------
  reg  [2:0]  state_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [7:0]  rx_sr_reg;
  reg  [7:0]  tx_sr_reg;
  reg  [7:0]  ptr_reg;
  reg  [1:0]  byte_idx_reg;
  reg  [2:0]  trim_hi_reg;
  reg         read_reg;
  wire [3:0]  sel_dec  = chan_of(rx_sr_reg);
  wire [3:0]  ptr_sel  = chan_of(ptr_reg);
  wire [3:0]  ptr_trim = chan_of(ptr_reg - `SAFE_TRIM_STEP);
  reg  [7:0]  rd_byte;
  integer     i;

  assign sda_o = 1'b0;

  // First byte of a read burst. It is latched at the address acknowledge,
  // and does not depend on the byte counter, so trim always gives its high
  // byte here; the low byte is loaded later, on the controller's acknowledge.
  always @* begin
    rd_byte = 8'h00;
    if (ptr_reg == `SAFE_IDX_GAIN) begin
      rd_byte = {5'h00, gain_reg};
    end else if (ptr_reg == `SAFE_IDX_CTRL) begin
      rd_byte = {4'h0, ctrl_reg};
    end else if (ptr_trim[3]) begin
      rd_byte = {5'h00, trim_mem[ptr_trim[2:0]][10:8]};
    end
  end

  // Target state machine; bytes are sampled on rising SCL and SDA is
  // changed only after a falling SCL, so setup holds at either rate.
  // R9 target only
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      state_reg    <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      rx_sr_reg    <= 8'h00;
      tx_sr_reg    <= 8'h00;
      ptr_reg      <= 8'h00;
      byte_idx_reg <= 2'd0;
      trim_hi_reg  <= 3'h0;
      read_reg     <= 1'b0;
      sda_oe       <= 1'b0;
      // R16 reset defaults
      chan_reg     <= `SAFE_RST_CHAN;
      gain_reg     <= `SAFE_RST_GAIN;
      ctrl_reg     <= `SAFE_RST_CTRL;
      for (i = 0; i < 8; i = i + 1) begin
        trim_mem[i] <= `SAFE_RST_TRIM;
      end
    end else if (start_det) begin
      // R12 address byte follows
      state_reg   <= ST_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe      <= 1'b0;
    end else if (stop_det) begin
      // R10 stop ends access
      state_reg <= ST_IDLE;
      sda_oe    <= 1'b0;
    end else begin
      case (state_reg)
        ST_ADDR, ST_RX: begin
          if (scl_rise && bit_cnt_reg != 4'd8) begin
            rx_sr_reg   <= {rx_sr_reg[6:0], sda_lvl_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'd1;
          end else if (scl_fall && bit_cnt_reg == 4'd8) begin
            if (state_reg == ST_ADDR) begin
              // R13 address match
              if (rx_sr_reg[7:1] == TARGET_ADDR) begin
                sda_oe       <= 1'b1;
                state_reg    <= ST_ACK;
                // R15 direction bit
                read_reg     <= rx_sr_reg[0];
                byte_idx_reg <= 2'd0;
                tx_sr_reg    <= rd_byte;
              end else begin
                // R18 foreign address
                state_reg <= ST_SKIP;
              end
            end else begin
              // R14 acknowledge written byte
              sda_oe    <= 1'b1;
              state_reg <= ST_ACK;
              if (byte_idx_reg != 2'd3) begin
                byte_idx_reg <= byte_idx_reg + 2'd1;
              end
              if (byte_idx_reg == 2'd0) begin
                ptr_reg <= rx_sr_reg;
                // R17 channel select
                if (sel_dec[3]) begin
                  chan_reg <= sel_dec[2:0];
                end
              end else if (byte_idx_reg == 2'd1) begin
                if (ptr_reg == `SAFE_IDX_GAIN) begin
                  gain_reg <= rx_sr_reg[2:0];
                end
                // R5 R6 R7 R8 control bits
                if (ptr_reg == `SAFE_IDX_CTRL) begin
                  ctrl_reg <= rx_sr_reg[3:0];
                end
                trim_hi_reg <= rx_sr_reg[2:0];
              end else if (byte_idx_reg == 2'd2 && ptr_trim[3]) begin
                // R1 R3 per-channel trim
                trim_mem[ptr_trim[2:0]] <= {trim_hi_reg, rx_sr_reg};
              end
            end
          end
        end
        ST_ACK: begin
          // Release after the acknowledge period, or start sending.
          if (scl_fall) begin
            if (read_reg) begin
              sda_oe      <= ~tx_sr_reg[7];
              tx_sr_reg   <= {tx_sr_reg[6:0], 1'b0};
              bit_cnt_reg <= 4'd1;
              state_reg   <= ST_TX;
            end else begin
              sda_oe      <= 1'b0;
              bit_cnt_reg <= 4'd0;
              state_reg   <= ST_RX;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            if (bit_cnt_reg == 4'd8) begin
              sda_oe    <= 1'b0;
              state_reg <= ST_RACK;
            end else begin
              sda_oe      <= ~tx_sr_reg[7];
              tx_sr_reg   <= {tx_sr_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'd1;
            end
          end
        end
        ST_RACK: begin
          // A not-acknowledge from the controller ends the read burst.
          if (scl_rise) begin
            if (sda_lvl_reg) begin
              state_reg <= ST_SKIP;
            end else begin
              if (byte_idx_reg != 2'd3) begin
                byte_idx_reg <= byte_idx_reg + 2'd1;
              end
              tx_sr_reg   <= {5'h00, 3'h0} | ((byte_idx_reg == 2'd0 &&
                             ptr_trim[3]) ?
                             trim_mem[ptr_trim[2:0]][7:0] : 8'h00);
              bit_cnt_reg <= 4'd0;
              state_reg   <= ST_TX;
            end
          end
        end
        default: begin
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Analog control outputs
  // --------------------------------------------------------------------------
  // Registered so the analog side never sees decoder glitches.
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      channel_selector            <= `SAFE_RST_CHAN;
      active_trim                 <= `SAFE_RST_TRIM;
      trim_sign_bit               <= 1'b0;
      amplifier_gain_code         <= `SAFE_RST_GAIN;
      programmable_amplifier_gain <= 10'd2;
      regulator_level_low         <= 1'b0;
      bridge_supply_regulator_en  <= 1'b1;
      current_sense_sel           <= 1'b0;
      analog_power_down           <= 1'b0;
    end else begin
      channel_selector    <= chan_reg;
      // R4 selected trim only
      active_trim         <= trim_mem[chan_reg];
      trim_sign_bit       <= trim_mem[chan_reg][`SAFE_TRIM_SIGN];
      amplifier_gain_code <= gain_reg;
      // R2 gain decode
      programmable_amplifier_gain <= gain_of(gain_reg);
      // R5 regulator level
      regulator_level_low <= ctrl_reg[`SAFE_CTRL_LEVEL];
      // R6 regulator off in sleep
      bridge_supply_regulator_en <= ~(ctrl_reg[`SAFE_CTRL_SLEEP] &
                                      ctrl_reg[`SAFE_CTRL_REG_OFF]);
      // R7 current sense route
      current_sense_sel   <= ctrl_reg[`SAFE_CTRL_ISENSE];
      // R8 sleep power down
      analog_power_down   <= ctrl_reg[`SAFE_CTRL_SLEEP];
    end
  end

  // Unused in logic; kept to document the worst-case bit period.
  localparam integer BIT_CYCLES = `SAFE_BIT_CYCLES;

endmodule // safe_ctrl

// *** sim/safe_ctrl_sva.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Pin-level checker for the control port
// ----------------------------------------------------------------------------
module safe_ctrl_sva (
  // Clock and reset
  input wire        ref_clk,
  input wire        sys_rst,
  // Serial pins
  input wire        scl_i,
  input wire        sda_i,
  input wire        sda_o,
  input wire        sda_oe,
  // Analog controls
  input wire [2:0]  channel_selector,
  input wire [10:0] active_trim,
  input wire        trim_sign_bit,
  input wire [2:0]  amplifier_gain_code,
  input wire [9:0]  programmable_amplifier_gain,
  input wire        regulator_level_low,
  input wire        bridge_supply_regulator_en,
  input wire        current_sense_sel,
  input wire        analog_power_down
);
  localparam logic [9:0] G_TAB [8] = '{10'h002, 10'h014, 10'h028, 10'h050,
    10'h096, 10'h12c, 10'h258, 10'h2f8};
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // Decoded outputs are given one cycle of slack behind their source.
  a_pin_low: assert property (sda_o == 1'b0)
    else $error("data pin output not held low");
  a_ack_width: assert property ($rose(sda_oe) |-> sda_oe [*8])
    else $error("data drive shorter than a bit");
  a_oe_scl_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed with clock high");
  a_idle_release: assert property (scl_i [*8] |-> !sda_oe)
    else $error("data driven while clock idles high");
  a_gain_decode: assert property ($stable(amplifier_gain_code) |->
    programmable_amplifier_gain == G_TAB[amplifier_gain_code])
    else $error("gain value does not match code");
  a_sign_bit: assert property ($stable(active_trim) |->
    trim_sign_bit == active_trim[10])
    else $error("sign output differs from trim bit");
  a_reg_awake: assert property (!analog_power_down &&
    $stable(analog_power_down) |-> bridge_supply_regulator_en)
    else $error("regulator off while awake");
  a_cfg_scl_low: assert property ($changed({amplifier_gain_code,
    analog_power_down, current_sense_sel, regulator_level_low}) |->
    !scl_i)
    else $error("configuration changed with clock high");
  a_reset_defaults: assert property ($fell(sys_rst) |->
    channel_selector == 3'h0 && amplifier_gain_code == 3'h0 &&
    bridge_supply_regulator_en && !analog_power_down && !sda_oe)
    else $error("wrong values after reset");
  c_ack: cover property ($rose(sda_oe));
  c_sleep: cover property ($rose(analog_power_down));
  c_last_chan: cover property (channel_selector == 3'h7);
endmodule // safe_ctrl_sva

bind safe_ctrl safe_ctrl_sva chk_u (.ref_clk, .sys_rst, .scl_i, .sda_i,
  .sda_o, .sda_oe, .channel_selector, .active_trim, .trim_sign_bit,
  .amplifier_gain_code, .programmable_amplifier_gain, .regulator_level_low,
  .bridge_supply_regulator_en, .current_sense_sel, .analog_power_down);

// *** sim/safe_host_model.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Serial controller model
// ----------------------------------------------------------------------------
module safe_host_model (
  // Link pins
  output reg  scl,
  output reg  sda_drv,
  input  wire sda
);
  // Quarter of the 64 ns link period; the clock stands high between frames.
  localparam time Q = 16;
  initial begin
    scl = 1'b1;
    sda_drv = 1'b0;
  end
  task start;
    sda_drv = 1'b0;
    scl = 1'b1;
    #(2*Q) sda_drv = 1'b1;
    #(2*Q) scl = 1'b0;
  endtask
  // Data moves a quarter period after the fall, so hold is kept.
  task put_bit(input b, output r);
    #Q sda_drv = !b;
    #Q scl = 1'b1;
    #(2*Q) r = sda;
    scl = 1'b0;
  endtask
  task xfer(input [7:0] d, input a, output [7:0] q, output k);
    for (int i = 7; i >= 0; i--) put_bit(d[i], q[i]);
    put_bit(a, k);
  endtask
  task stop;
    #Q sda_drv = 1'b1;
    #Q scl = 1'b1;
    #(2*Q) sda_drv = 1'b0;
    #(4*Q);
  endtask
endmodule // safe_host_model

// *** sim/testbench.sv ***
`timescale 1ns/1ps
`include "safe_defs.vh"
// ----------------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------------
module testbench;
  localparam [6:0] ADDR = `SAFE_TARGET_ADDR;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  wire scl_i, sda_i, sda_o, sda_oe, host_drv;
  wire trim_sign_bit, regulator_level_low, bridge_supply_regulator_en;
  wire current_sense_sel, analog_power_down;
  wire [2:0] channel_selector, amplifier_gain_code;
  wire [10:0] active_trim;
  wire [9:0] programmable_amplifier_gain;
  int miscompares = 0;
  int samples_checked = 0;
  int trim [8] = '{default: 0};
  int chan = 0, gain = 0, ctrl = 0;
  int gtab [8] = '{2, 20, 40, 80, 150, 300, 600, 760};
  int bnd [4] = '{11'h3ff, 11'h7ff, 11'h400, 11'h000};
  logic [7:0] sidx [8] = '{8'h10, 8'h12, 8'h14, 8'h15, 8'h18, 8'h1a,
    8'h1c, 8'h1e};
  logic [15:0] v;
  // Reference clock at 200 MHz.
  always #2.5 ref_clk = ~ref_clk;
  // The data line has a pull-up; any enabled driver pulls it low.
  assign sda_i = ~(host_drv | sda_oe);
  safe_ctrl dut_u (.ref_clk, .sys_rst, .scl_i, .sda_i, .sda_o, .sda_oe,
    .channel_selector, .active_trim, .trim_sign_bit, .amplifier_gain_code,
    .programmable_amplifier_gain, .regulator_level_low,
    .bridge_supply_regulator_en, .current_sense_sel, .analog_power_down);
  safe_host_model host_u (.scl(scl_i), .sda_drv(host_drv), .sda(sda_i));
  task chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      miscompares++;
      $display("Error at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Every analog control output against the reference model.
  task check_all;
    chk(channel_selector, chan);
    chk(active_trim, trim[chan]);
    chk(trim_sign_bit, trim[chan] >> 10);
    chk(amplifier_gain_code, gain);
    chk(programmable_amplifier_gain, gtab[gain]);
    chk(regulator_level_low, ctrl[1]);
    chk(bridge_supply_regulator_en, !(ctrl[0] && ctrl[2]));
    chk(current_sense_sel, ctrl[3]);
    chk(analog_power_down, ctrl[0]);
  endtask
  // A foreign address must see no acknowledge anywhere in the frame.
  task automatic wr(input [6:0] a, input [7:0] x, input int n,
                    input [15:0] d);
    logic [7:0] q;
    logic k;
    host_u.start();
    host_u.xfer({a, 1'b0}, 1'b1, q, k);
    chk(k, a != ADDR);
    host_u.xfer(x, 1'b1, q, k);
    chk(k, a != ADDR);
    for (int i = 0; i < n; i++) begin
      host_u.xfer(d[15-8*i -: 8], 1'b1, q, k);
      chk(k, a != ADDR);
    end
    host_u.stop();
  endtask
  task automatic rd(input [7:0] x, input int n);
    logic [7:0] q;
    logic k;
    wr(ADDR, x, 0, 16'h0000);
    host_u.start();
    host_u.xfer({ADDR, 1'b1}, 1'b1, q, k);
    chk(k, 1'b0);
    for (int i = 0; i < n; i++) begin
      host_u.xfer(8'hff, i == n - 1, q, k);
      v = {v[7:0], q};
    end
    host_u.stop();
  endtask
  // Main sequence.
  initial begin
    void'($urandom(66426));
    // Three rising edges inside reset, so no checker sees an unset history.
    repeat (3) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (6) @(negedge ref_clk);
    check_all();
    wr(ADDR ^ 7'h01, `SAFE_IDX_GAIN, 1, 16'h0500);
    check_all();
    $display("reset and address test done");
    for (int g = 0; g < 8; g++) begin
      wr(ADDR, `SAFE_IDX_GAIN, 1, {g[7:0], 8'h00});
      gain = g;
      check_all();
    end
    $display("gain test done");
    for (int k = 0; k < 8; k++) begin
      trim[k] = (k < 4) ? bnd[k] : $urandom % 2048;
      wr(ADDR, sidx[k] + `SAFE_TRIM_STEP, 2, trim[k][15:0]);
      check_all();
    end
    for (int k = 7; k >= 0; k--) begin
      wr(ADDR, sidx[k], 0, 16'h0000);
      chan = k;
      check_all();
    end
    $display("trim and channel test done");
    for (int c = 0; c < 16; c++) begin
      wr(ADDR, `SAFE_IDX_CTRL, 1, {c[7:0], 8'h00});
      ctrl = c;
      check_all();
    end
    wr(ADDR, `SAFE_IDX_GAIN, 1, 16'h0500);
    gain = 5;
    check_all();
    $display("control test done");
    rd(sidx[5] + `SAFE_TRIM_STEP, 2);
    chk(v[10:0], trim[5]);
    rd(`SAFE_IDX_GAIN, 1);
    chk(v[7:0], gain);
    $display("read test done");
    stop_test();
  end
  // A hang ends the run as a mismatch.
  initial begin
    #400_000;
    miscompares++;
    stop_test();
  end
endmodule // testbench
